// [hdl/srfc_pkg.sv]
package srfc_pkg;
   // ************************************************************
   // register map (axi read byte addresses = index * 4; words are written at 0x00)
   // ************************************************************
   localparam logic [3:0] SRFC_IDX_GAIN = 4'h6;
   localparam logic [3:0] SRFC_IDX_PHASE = 4'h7;
   localparam logic [3:0] SRFC_IDX_CHAN = 4'h8;
   localparam logic [3:0] SRFC_IDX_MODE = 4'h9;
   localparam logic [3:0] SRFC_IDX_STAT = 4'ha;
   localparam int SRFC_ADDR_W = 8;
   localparam logic [7:0] SRFC_ADDR_WORD = 8'h00;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int SRFC_AD_LSB = 12;
   localparam int SRFC_GLFR_LSB = 8;
   localparam int SRFC_GLFC_LSB = 4;
   localparam int SRFC_ALPHA_LSB = 0;
   localparam int SRFC_DPDLPF_BIT = 11;
   localparam int SRFC_STRETCH_LSB = 7;
   localparam int SRFC_TEST_BIT = 6;
   localparam int SRFC_ENH_BIT = 5;
   localparam int SRFC_EQRF_LSB = 2;
   localparam int SRFC_FSTART_LSB = 0;
   // ************************************************************
   // reset values and code limits
   // ************************************************************
   localparam logic [3:0] SRFC_GAIN_RST = 4'h0;
   localparam logic [3:0] SRFC_GAIN_MAX = 4'h8;
   localparam logic [3:0] SRFC_ALPHA_RST = 4'h8;
   localparam logic [2:0] SRFC_STRETCH_RST = 3'h1;
   localparam logic [2:0] SRFC_EQRF_RST = 3'h1;
   localparam logic [1:0] SRFC_FSTART_RST = 2'h0;
   localparam logic [7:0] SRFC_CHAN_RST = 8'h00;
   // stretch selection, named by pulse width
   localparam logic [2:0] SRFC_TP_1N9 = 3'h0;
   localparam logic [2:0] SRFC_TP_3N8 = 3'h1;
   localparam logic [2:0] SRFC_TP_7N5 = 3'h2;
   localparam logic [2:0] SRFC_TP_15N = 3'h3;
   localparam logic [2:0] SRFC_TP_30N = 3'h4;
   localparam logic [2:0] SRFC_TP_1N2 = 3'h5;
   localparam logic [1:0] SRFC_RESP_OK = 2'h0;
   localparam logic [1:0] SRFC_RESP_ERR = 2'h2;
endpackage : srfc_pkg

// [hdl/srfc_word_reg.sv]
`timescale 1ns/10ps
// one stored control word, read data registered
module srfc_word_reg #(
   parameter int W = 16,
   parameter logic [15:0] RST = 16'h0000
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // write side
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   // stored value
   output logic [W-1:0] q
);
   logic [W-1:0] q_nxt;
   if (W < 1 || W > 16) begin : g_bad_w
      $error("word width out of range");
   end
   always_comb begin
      q_nxt = q;
      if (wr_en) begin
         q_nxt = wr_data;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         q <= RST[W-1:0];
      end else begin
         q <= q_nxt;
      end
   end
endmodule : srfc_word_reg

// [hdl/srfc_ctrl.sv]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module srfc_ctrl
   import srfc_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_B,
   // axi4-lite write address
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // axi4-lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read address
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // axi4-lite read data
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // servo gains and offset factor
   output logic [3:0] RADIAL_LOWFREQ_GAIN,
   output logic [3:0] CENTRAL_LOWFREQ_GAIN,
   output logic [3:0] OFFSET_FACTOR,
   // phase detector and rf filters, effective values
   output logic PHASE_DETECTOR_LOWPASS_SEL,
   output logic [2:0] PULSE_STRETCH_SEL,
   output logic FACTORY_TEST_BIT,
   output logic ENHANCED_FILTER_ENABLE,
   output logic [2:0] RF_LOWPASS_SEL,
   output logic [1:0] LEADLAG_START_FREQ,
   // channel switches, bit 3 d .. bit 0 a
   output logic [3:0] CHAN_MUTE,
   output logic [3:0] CHAN_INVERT
);
   // ************************************************************
   // bus slave state
   // ************************************************************
   logic aw_held_r, aw_held_nxt, awready_r;
   logic w_held_r, w_held_nxt, wready_r;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic wfull_r, wfull_nxt, wlow_r, wlow_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt, arready_r;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic compat_r, compat_nxt;
   logic [3:0] last_sel_r, last_sel_nxt;
   logic bad_sel_r, bad_sel_nxt;
   logic do_write;
   logic [3:0] sel;
   logic wr_gain, wr_phase, wr_chan;
   logic [15:0] gain_q, phase_q, chan_q;
   logic [15:0] wr_word;
   assign do_write = aw_held_r && w_held_r && !bvalid_r;
   // word sent as a whole; the address nibble travels inside it
   assign wr_word = wdata_r;
   assign sel = wr_word[SRFC_AD_LSB+:4];
   always_comb begin
      wr_gain = 1'b0;
      wr_phase = 1'b0;
      wr_chan = 1'b0;
      // only the addressed register is touched
      if (do_write && awaddr_r == SRFC_ADDR_WORD && wfull_r) begin
         if (sel == SRFC_IDX_GAIN) begin
            wr_gain = 1'b1;
         end else if (sel == SRFC_IDX_PHASE) begin
            wr_phase = 1'b1;
         end else if (sel == SRFC_IDX_CHAN) begin
            wr_chan = 1'b1;
         end
      end
   end
   // ************************************************************
   // write channel
   // ************************************************************
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wfull_nxt = wfull_r;
      wlow_nxt = wlow_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      compat_nxt = compat_r;
      last_sel_nxt = last_sel_r;
      bad_sel_nxt = bad_sel_r;
      if (S_AXI_AWVALID && !aw_held_r) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_r) begin
         w_held_nxt = 1'b1;
         wdata_nxt = S_AXI_WDATA[15:0];
         wfull_nxt = S_AXI_WSTRB[0] && S_AXI_WSTRB[1];
         wlow_nxt = S_AXI_WSTRB[0];
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = SRFC_RESP_OK;
         if (awaddr_r == SRFC_ADDR_WORD) begin
            if (wfull_r) begin
               last_sel_nxt = sel;
               // unknown register numbers are dropped, noted in status
               bad_sel_nxt = !(wr_gain || wr_phase || wr_chan);
            end
         end else if (awaddr_r == {2'b00, SRFC_IDX_MODE, 2'b00}) begin
            if (wlow_r) begin // latched strobe: live bus may carry the next beat
               compat_nxt = wdata_r[0];
            end
         end else begin
            bresp_nxt = SRFC_RESP_ERR;
         end
      end
      if (bvalid_r && S_AXI_BREADY) begin
         bvalid_nxt = 1'b0;
      end
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 16'h0000;
         wfull_r <= 1'b0;
         wlow_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= SRFC_RESP_OK;
         compat_r <= 1'b0;
         last_sel_r <= 4'h0;
         bad_sel_r <= 1'b0;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wfull_r <= wfull_nxt;
         wlow_r <= wlow_nxt;
         awready_r <= !aw_held_nxt;
         wready_r <= !w_held_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         compat_r <= compat_nxt;
         last_sel_r <= last_sel_nxt;
         bad_sel_r <= bad_sel_nxt;
      end
   end
   // ready kept as its own flop so the port has no gate behind it
   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY = wready_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   // ************************************************************
   // stored control words
   // ************************************************************
   srfc_word_reg #(
      .W(16),
      .RST({SRFC_IDX_GAIN, SRFC_GAIN_RST, SRFC_GAIN_RST, SRFC_ALPHA_RST})
   ) u_gain (
      .clock(CLOCK),
      .rst_b(RST_B),
      .wr_en(wr_gain),
      .wr_data(wr_word),
      .q(gain_q)
   );
   srfc_word_reg #(
      .W(16),
      .RST({SRFC_IDX_PHASE, 2'b00, SRFC_STRETCH_RST, 2'b00, SRFC_EQRF_RST, SRFC_FSTART_RST})
   ) u_phase (
      .clock(CLOCK),
      .rst_b(RST_B),
      .wr_en(wr_phase),
      .wr_data(wr_word),
      .q(phase_q)
   );
   srfc_word_reg #(
      .W(16),
      .RST({SRFC_IDX_CHAN, 4'h0, SRFC_CHAN_RST})
   ) u_chan (
      .clock(CLOCK),
      .rst_b(RST_B),
      .wr_en(wr_chan),
      .wr_data(wr_word),
      .q(chan_q)
   );
   // ************************************************************
   // read channel: words, mode and status
   // ************************************************************
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (S_AXI_ARVALID && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = SRFC_RESP_OK;
         rdata_nxt = 32'h0000_0000;
         if (S_AXI_ARADDR == {2'b00, SRFC_IDX_GAIN, 2'b00}) begin
            rdata_nxt = {16'h0000, gain_q};
         end else if (S_AXI_ARADDR == {2'b00, SRFC_IDX_PHASE, 2'b00}) begin
            rdata_nxt = {16'h0000, phase_q};
         end else if (S_AXI_ARADDR == {2'b00, SRFC_IDX_CHAN, 2'b00}) begin
            rdata_nxt = {16'h0000, chan_q};
         end else if (S_AXI_ARADDR == {2'b00, SRFC_IDX_MODE, 2'b00}) begin
            rdata_nxt = {31'h0000_0000, compat_r};
         end else if (S_AXI_ARADDR == {2'b00, SRFC_IDX_STAT, 2'b00}) begin
            rdata_nxt = {27'h000_0000, bad_sel_r, last_sel_r};
         end else begin
            rresp_nxt = SRFC_RESP_ERR;
         end
      end else if (rvalid_r && S_AXI_RREADY) begin
         rvalid_nxt = 1'b0;
      end
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
         rresp_r <= SRFC_RESP_OK;
      end else begin
         rvalid_r <= rvalid_nxt;
         arready_r <= !rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   // ************************************************************
   // effective settings
   // ************************************************************
   logic [3:0] rgain_nxt, cgain_nxt, alpha_nxt;
   logic lpf_nxt, test_nxt, enh_nxt;
   logic [2:0] stretch_nxt, eqrf_nxt;
   logic [1:0] fstart_nxt;
   logic [2:0] raw_st;
   always_comb begin
      rgain_nxt = gain_q[SRFC_GLFR_LSB+:4];
      cgain_nxt = gain_q[SRFC_GLFC_LSB+:4];
      alpha_nxt = gain_q[SRFC_ALPHA_LSB+:4];
      raw_st = phase_q[SRFC_STRETCH_LSB+:3];
      // passed through in compat mode or with the enhanced bit set, else cleared; host keeps it normal
      test_nxt = phase_q[SRFC_TEST_BIT];
      lpf_nxt = 1'b0;
      enh_nxt = 1'b0;
      eqrf_nxt = SRFC_EQRF_RST;
      fstart_nxt = SRFC_FSTART_RST;
      // output names a pulse width, same code space as flag 0
      stretch_nxt = SRFC_TP_3N8;
      if (!compat_r) begin
         enh_nxt = phase_q[SRFC_ENH_BIT];
         eqrf_nxt = phase_q[SRFC_EQRF_LSB+:3];
         fstart_nxt = phase_q[SRFC_FSTART_LSB+:2];
         if (enh_nxt) begin
            lpf_nxt = phase_q[SRFC_DPDLPF_BIT];
            stretch_nxt = raw_st;
         end else begin
            test_nxt = 1'b0;
         end
      end else begin
         case (raw_st)
            3'h0: stretch_nxt = SRFC_TP_30N;
            3'h1: stretch_nxt = SRFC_TP_15N;
            3'h2: stretch_nxt = SRFC_TP_7N5;
            3'h3: stretch_nxt = SRFC_TP_3N8;
            3'h4: stretch_nxt = SRFC_TP_1N9;
            3'h5: stretch_nxt = SRFC_TP_1N2;
            default: stretch_nxt = raw_st;
         endcase
      end
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         RADIAL_LOWFREQ_GAIN <= SRFC_GAIN_RST;
         CENTRAL_LOWFREQ_GAIN <= SRFC_GAIN_RST;
         OFFSET_FACTOR <= SRFC_ALPHA_RST;
         PHASE_DETECTOR_LOWPASS_SEL <= 1'b0;
         PULSE_STRETCH_SEL <= SRFC_TP_3N8;
         FACTORY_TEST_BIT <= 1'b0;
         ENHANCED_FILTER_ENABLE <= 1'b0;
         RF_LOWPASS_SEL <= SRFC_EQRF_RST;
         LEADLAG_START_FREQ <= SRFC_FSTART_RST;
         CHAN_MUTE <= 4'h0;
         CHAN_INVERT <= 4'h0;
      end else begin
         RADIAL_LOWFREQ_GAIN <= rgain_nxt;
         CENTRAL_LOWFREQ_GAIN <= cgain_nxt;
         OFFSET_FACTOR <= alpha_nxt;
         PHASE_DETECTOR_LOWPASS_SEL <= lpf_nxt;
         PULSE_STRETCH_SEL <= stretch_nxt;
         FACTORY_TEST_BIT <= test_nxt;
         ENHANCED_FILTER_ENABLE <= enh_nxt;
         RF_LOWPASS_SEL <= eqrf_nxt;
         LEADLAG_START_FREQ <= fstart_nxt;
         CHAN_MUTE <= {chan_q[7], chan_q[5], chan_q[3], chan_q[1]};
         CHAN_INVERT <= {chan_q[6], chan_q[4], chan_q[2], chan_q[0]};
      end
   end
endmodule : srfc_ctrl

// [bench/srfc_ctrl_asserts.sv]
`timescale 1ns/10ps
module srfc_ctrl_asserts
   import srfc_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_B,
   // bus handshakes
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   // control outputs
   input wire logic [3:0] RADIAL_LOWFREQ_GAIN,
   input wire logic [3:0] CENTRAL_LOWFREQ_GAIN,
   input wire logic [3:0] OFFSET_FACTOR,
   input wire logic PHASE_DETECTOR_LOWPASS_SEL,
   input wire logic [2:0] PULSE_STRETCH_SEL,
   input wire logic FACTORY_TEST_BIT,
   input wire logic ENHANCED_FILTER_ENABLE,
   input wire logic [2:0] RF_LOWPASS_SEL,
   input wire logic [1:0] LEADLAG_START_FREQ,
   input wire logic [3:0] CHAN_MUTE,
   input wire logic [3:0] CHAN_INVERT
);
   // ************************************************************
   // shadow of the last word and of the mode flag
   // ************************************************************
   logic tk;
   logic [15:0] w_r;
   logic mode_r;
   assign tk = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   // both channels taken together: the host model never splits them
   always_ff @(posedge CLOCK) begin
      if (tk && S_AXI_AWADDR == SRFC_ADDR_WORD) w_r <= S_AXI_WDATA[15:0];
      if (!RST_B) mode_r <= 1'b0;
      else if (tk && S_AXI_AWADDR == 8'h24 && S_AXI_WSTRB[0]) mode_r <= S_AXI_WDATA[0];
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   sequence word_taken;
      tk && S_AXI_AWADDR == SRFC_ADDR_WORD && S_AXI_WSTRB[1:0] == 2'b11;
   endsequence
   sequence phase_taken;
      word_taken ##0 S_AXI_WDATA[15:12] == SRFC_IDX_PHASE;
   endsequence
   AST_GAIN_FIELDS: assert property (word_taken ##0 S_AXI_WDATA[15:12] == SRFC_IDX_GAIN
      |-> ##3 {RADIAL_LOWFREQ_GAIN, CENTRAL_LOWFREQ_GAIN, OFFSET_FACTOR} == w_r[11:0])
      else $error("gain word not applied");
   AST_PHASE_LEGACY: assert property (phase_taken ##0 !mode_r && !S_AXI_WDATA[5]
      |-> ##3 {PHASE_DETECTOR_LOWPASS_SEL, PULSE_STRETCH_SEL, FACTORY_TEST_BIT} == 5'b00010
      && !ENHANCED_FILTER_ENABLE && RF_LOWPASS_SEL == w_r[4:2]
      && LEADLAG_START_FREQ == w_r[1:0]) else $error("legacy phase fields wrong");
   AST_PHASE_ENH: assert property (phase_taken ##0 !mode_r && S_AXI_WDATA[5]
      |-> ##3 PHASE_DETECTOR_LOWPASS_SEL == w_r[11] && PULSE_STRETCH_SEL == w_r[9:7]
      && ENHANCED_FILTER_ENABLE) else $error("enhanced phase fields wrong");
   AST_PHASE_COMPAT: assert property (phase_taken ##0 mode_r
      |-> ##3 PULSE_STRETCH_SEL == (w_r[9:7] > 3'h4 ? w_r[9:7] : 3'h4 - w_r[9:7])
      && RF_LOWPASS_SEL == SRFC_EQRF_RST && LEADLAG_START_FREQ == SRFC_FSTART_RST
      && !PHASE_DETECTOR_LOWPASS_SEL) else $error("compat stretch wrong");
   AST_CHAN_FIELDS: assert property (word_taken ##0 S_AXI_WDATA[15:12] == SRFC_IDX_CHAN
      |-> ##3 CHAN_MUTE == {w_r[7], w_r[5], w_r[3], w_r[1]}
      && CHAN_INVERT == {w_r[6], w_r[4], w_r[2], w_r[0]}) else $error("switch word wrong");
   AST_IGNORE_OTHER: assert property (word_taken ##0 !(S_AXI_WDATA[15:12] inside {4'h6, 4'h7, 4'h8})
      |=> ($stable(OFFSET_FACTOR) && $stable(CHAN_MUTE) && $stable(PULSE_STRETCH_SEL))[*3])
      else $error("foreign word changed outputs");
   AST_RESET_DEFAULT: assert property ($rose(RST_B) |-> OFFSET_FACTOR == SRFC_ALPHA_RST
      && RADIAL_LOWFREQ_GAIN == SRFC_GAIN_RST && PULSE_STRETCH_SEL == SRFC_STRETCH_RST
      && CHAN_MUTE == 4'h0 && !S_AXI_BVALID) else $error("reset values wrong");
   AST_WRITE_ANSWER: assert property (word_taken |-> ##2 S_AXI_BVALID)
      else $error("no write response");
   AST_BAD_ADDR: assert property (tk && S_AXI_AWADDR > 8'h28
      |-> ##2 S_AXI_BVALID && S_AXI_BRESP == SRFC_RESP_ERR) else $error("unmapped write not refused");
   AST_READ_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("no read response");
endmodule : srfc_ctrl_asserts

// [bench/srfc_host_model.sv]
`timescale 1ns/10ps
module srfc_host_model
   import srfc_pkg::*;
(
   // clock
   input wire logic CLOCK,
   // write side
   output logic [7:0] S_AXI_AWADDR,
   output logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   output logic [31:0] S_AXI_WDATA,
   output logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   output logic S_AXI_BREADY,
   // read side
   output logic [7:0] S_AXI_ARADDR,
   output logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   output logic S_AXI_RREADY
);
   // ************************************************************
   // bus master tasks
   // ************************************************************
   initial begin
      {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_WSTRB, S_AXI_ARADDR} = '0;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge CLOCK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= 4'hf;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge CLOCK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask : rd
   // a well-behaved host; raw writes go through wr directly
   task automatic word(input logic [15:0] w, output logic [1:0] r);
      logic [15:0] c;
      c = w;
      if (w[15:12] == SRFC_IDX_PHASE) c[SRFC_TEST_BIT] = 1'b0;
      if (w[15:12] == SRFC_IDX_CHAN) c[11:8] = 4'h0;
      wr(SRFC_ADDR_WORD, {16'h0000, c}, r);
   endtask : word
endmodule : srfc_host_model

// [bench/tb.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb
   import srfc_pkg::*;
   ;
   // ************************************************************
   // design, host and stimulus table
   // ************************************************************
   typedef struct packed {logic m; logic [15:0] w; logic [11:0] e;} srfc_row_s;
   logic CLOCK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
   logic [3:0] S_AXI_WSTRB, RADIAL_LOWFREQ_GAIN, CENTRAL_LOWFREQ_GAIN, OFFSET_FACTOR;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, LEADLAG_START_FREQ, resp;
   logic PHASE_DETECTOR_LOWPASS_SEL, FACTORY_TEST_BIT, ENHANCED_FILTER_ENABLE, mode_now;
   logic [2:0] PULSE_STRETCH_SEL, RF_LOWPASS_SEL;
   logic [3:0] CHAN_MUTE, CHAN_INVERT;
   logic [11:0] seen;
   srfc_row_s rows [15];
   int n_fail = 0;
   int checked = 0;
   srfc_ctrl uut (.*);
   srfc_host_model host (.*);
   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   // generous: the whole run is under two hundred cycles
   initial begin
      repeat (5000) @(posedge CLOCK);
      n_fail++;
      print_verdict();
   end
   initial begin
      RST_B = 1'b0;
      mode_now = 1'b0;
      rows = '{'{1'b0, 16'h6000, 12'h000}, '{1'b0, 16'h688f, 12'h88f}, '{1'b0, 16'h6358, 12'h358},
         '{1'b0, 16'h7a0e, 12'h04e}, '{1'b0, 16'h7a2e, 12'h32e}, '{1'b0, 16'h7025, 12'h025},
         '{1'b1, 16'h781f, 12'h104}, '{1'b1, 16'h7080, 12'h0c4}, '{1'b1, 16'h7100, 12'h084},
         '{1'b1, 16'h7180, 12'h044}, '{1'b1, 16'h7200, 12'h004}, '{1'b1, 16'h7280, 12'h144},
         '{1'b1, 16'h80aa, 12'h0f0}, '{1'b1, 16'h8055, 12'h00f}, '{1'b1, 16'h8096, 12'h096}};
      repeat (2) @(posedge CLOCK);
      RST_B <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].m !== mode_now) begin
            host.wr(8'h24, {31'h0, rows[i].m}, resp);
            mode_now = rows[i].m;
         end
         host.word(rows[i].w, resp);
         `CHK("word response", SRFC_RESP_OK, resp)
         repeat (2) @(posedge CLOCK);
         case (rows[i].w[15:12])
            SRFC_IDX_GAIN: seen = {RADIAL_LOWFREQ_GAIN, CENTRAL_LOWFREQ_GAIN, OFFSET_FACTOR};
            SRFC_IDX_PHASE: seen = {2'b00, PHASE_DETECTOR_LOWPASS_SEL, PULSE_STRETCH_SEL,
               ENHANCED_FILTER_ENABLE, RF_LOWPASS_SEL, LEADLAG_START_FREQ};
            default: seen = {4'h0, CHAN_MUTE, CHAN_INVERT};
         endcase
         `CHK("decoded fields", rows[i].e, seen)
      end
      // words for other registers must leave these outputs alone
      host.word(16'h9123, resp);
      host.word(16'h5fff, resp);
      repeat (2) @(posedge CLOCK);
      `CHK("switches kept", 8'h96, {CHAN_MUTE, CHAN_INVERT})
      `CHK("factor kept", 4'h8, OFFSET_FACTOR)
      host.rd(8'h28, rd, resp);
      `CHK("status", 32'h0000_0015, rd)
      host.wr(SRFC_ADDR_WORD, 32'h0000_8f81, resp);
      repeat (2) @(posedge CLOCK);
      `CHK("unused bits", 8'h81, {CHAN_MUTE, CHAN_INVERT})
      host.wr(8'h40, 32'h0000_6fff, resp);
      `CHK("unmapped write", SRFC_RESP_ERR, resp)
      repeat (2) @(posedge CLOCK);
      `CHK("gain kept", 4'h3, RADIAL_LOWFREQ_GAIN)
      host.rd(8'h3c, rd, resp);
      `CHK("unmapped read", {SRFC_RESP_ERR, 32'h0}, {resp, rd})
      host.rd(8'h24, rd, resp);
      `CHK("mode flag", 1'b1, rd[0])
      // second reset in mid-run
      @(posedge CLOCK);
      RST_B <= 1'b0;
      repeat (2) @(posedge CLOCK);
      RST_B <= 1'b1;
      @(posedge CLOCK);
      `CHK("reset gains", 12'h008, {RADIAL_LOWFREQ_GAIN, CENTRAL_LOWFREQ_GAIN, OFFSET_FACTOR})
      `CHK("reset phase", 11'h084, {PHASE_DETECTOR_LOWPASS_SEL, PULSE_STRETCH_SEL, FACTORY_TEST_BIT,
         ENHANCED_FILTER_ENABLE, RF_LOWPASS_SEL, LEADLAG_START_FREQ})
      `CHK("reset switches", 8'h00, {CHAN_MUTE, CHAN_INVERT})
      print_verdict();
   end
endmodule : tb
bind srfc_ctrl srfc_ctrl_asserts chk (.*);
